// >>> rtl/serial_port_pkg.sv
package serial_port_pkg;

  localparam int NCH = 2;

  // APB map: bit 5 of the byte address picks the channel
  localparam int          CH_SEL_BIT = 5;
  localparam logic [4:0] OFS_TXSC   = 5'h00;
  localparam logic [4:0] OFS_RXSC   = 5'h04;
  localparam logic [4:0] OFS_TXDAT  = 5'h08;
  localparam logic [4:0] OFS_RXDAT  = 5'h0c;
  localparam logic [4:0] OFS_BAUD   = 5'h10;

  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE_SELECT  = 7;
  localparam int TX_NINE  = 6;
  localparam int TX_EN    = 5;
  localparam int TX_SYNC  = 4;
  localparam int TX_HIGH  = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_D9    = 0;
  // receive_status_control fields
  localparam int RX_SERIAL_PORT_ENABLE  = 7;
  localparam int RX_NINE  = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RX_FERR  = 2;
  localparam int RX_OERR  = 1;
  localparam int RX_D9    = 0;

  localparam logic [7:0] TXSC_RESET = 8'h02;
  localparam logic [7:0] RXSC_RESET = 8'h00;
  localparam logic [7:0] TXSC_WMASK = 8'hf5;
  localparam logic [7:0] RXSC_WMASK = 8'hf8;

  // Baud ticks per asynchronous bit, less one
  localparam logic [6:0] OVS_LO = 7'h3f;
  localparam logic [6:0] OVS_HI = 7'h0f;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } rx_state_e;

  typedef struct packed {
    logic data_in;
    logic clock_in;
  } pin_in_s;

  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clock_out;
    logic clock_oe;
  } pin_out_s;

  typedef struct packed {
    logic [7:0]  txsc;
    logic [7:0]  rxsc;
    logic [7:0]  txbuf;
    logic [7:0]  rxbuf;
    logic [7:0]  baud;
    logic [7:0]  bcnt;
    logic        tx_full;
    tx_state_e   tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_left;
    logic [6:0]  tx_sub;
    logic        ck;
    logic        ck_in_prev;
    rx_state_e   rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_left;
    logic [6:0]  rx_sub;
    logic        rx_full;
  } chan_s;

  typedef struct packed {
    chan_s [NCH-1:0] ch;
    logic [31:0]     rdata;
    logic            err;
  } state_s;

  localparam chan_s CH_RESET = '{txsc: TXSC_RESET, rxsc: RXSC_RESET, tx_sh: 11'h7ff,
                                 tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};

endpackage

// >>> rtl/serial_port_pair.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// [RULE_01] Modes: asynchronous full duplex, synchronous master, synchronous slave.
// [RULE_02] Two channels, each configured independently of the other.
// [RULE_03] Each channel has its own control, status, data and baud registers.
// [RULE_04] Software sets serial_port_enable before using the serial pins.
// [RULE_05] Software sets receive_data_pin direction to input in every mode; the port drives it as an output while shifting in synchronous mode.
// [RULE_06] Software makes transmit_clock_pin an output in asynchronous and master mode.
// [RULE_07] Software makes transmit_clock_pin an input in synchronous slave mode.
// [RULE_08] Synchronous: clock_source_select one drives clock from baud generator, zero takes it.
// [RULE_09] Transmitter runs only while transmitter_enable is one.
// [RULE_10] serial_port_enable one takes over both pins; zero disables the port.
// [RULE_11] Sync bit picks synchronous; nine_bit_transmit sends ninth data bit.
module serial_port_pair
  import serial_port_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire pin_in_s  [NCH-1:0]   pin_in,
  output pin_out_s      [NCH-1:0]   pin_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] decode(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a[7:6] == 2'h0) begin
      case (a[4:0])
        OFS_TXSC:  r = 3'h0;
        OFS_RXSC:  r = 3'h1;
        OFS_TXDAT: r = 3'h2;
        OFS_RXDAT: r = 3'h3;
        OFS_BAUD:  r = 3'h4;
        default:   r = 3'h7;
      endcase
    end
    return r;
  endfunction

  function automatic logic [6:0] ovs(input logic high);
    return high ? OVS_HI : OVS_LO;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_s st;
  state_s next_st;

  logic [2:0] sel_reg;
  logic       sel_ch;
  logic       setup;
  logic       access;

  assign sel_reg = decode(paddr);
  assign sel_ch  = paddr[CH_SEL_BIT];
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  // Zero wait states; read data is captured during setup
  assign pready  = 1'b1;
  assign prdata  = st.rdata;
  assign pslverr = access & st.err;

  always_comb begin
    chan_s c;
    chan_s n;
    logic  serial_port_enable;
    logic  sync;
    logic  tick;
    logic  tx_ok;
    logic  rx_ok;
    logic  mine;
    c = CH_RESET;
    n = CH_RESET;
    serial_port_enable = 1'b0;
    sync = 1'b0;
    tick = 1'b0;
    tx_ok = 1'b0;
    rx_ok = 1'b0;
    mine = 1'b0;
    next_st = st;
    if (setup) begin
      next_st.err   = (sel_reg == 3'h7);
      next_st.rdata = 32'h0000_0000;
      c = st.ch[sel_ch];
      case (sel_reg)
        3'h0:    next_st.rdata = {24'h00_0000, c.txsc};
        3'h1:    next_st.rdata = {24'h00_0000, c.rxsc};
        3'h3:    next_st.rdata = {23'h00_0000, c.rx_full, c.rxbuf};
        3'h4:    next_st.rdata = {24'h00_0000, c.baud};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    for (int i = 0; i < NCH; i++) begin // [RULE_02]
      c = st.ch[i];
      n = c;
      mine = access & (sel_ch == 1'(i));
      serial_port_enable = c.rxsc[RX_SERIAL_PORT_ENABLE];
      sync = c.txsc[TX_SYNC]; // [RULE_11]
      // Baud generator reloads from the baud register
      tick = (c.bcnt == 8'h00);
      if (!serial_port_enable) begin
        n.bcnt = c.baud; // [RULE_10]
      end else begin
        n.bcnt = tick ? c.baud : c.bcnt - 8'h01;
      end
      // Receive enables take the half-duplex line from the transmitter
      tx_ok = serial_port_enable & c.txsc[TX_EN] & ~(sync & (c.rxsc[RX_SINGLE_RECEIVE_ENABLE] | c.rxsc[RX_CONTINUOUS_RECEIVE_ENABLE])); // [RULE_09]
      rx_ok = serial_port_enable & c.rxsc[RX_CONTINUOUS_RECEIVE_ENABLE] & ~sync;
      n.ck_in_prev = pin_in[i].clock_in;

      //////////////////////////////////////////////////////////////////////
      case (c.tx_st)
        TX_IDLE: begin
          n.ck = 1'b0;
          if (tx_ok && c.tx_full) begin
            n.tx_full = 1'b0;
            if (!sync) begin
              n.tx_sh   = {1'b1, c.txsc[TX_NINE] ? c.txsc[TX_D9] : 1'b1, c.txbuf, 1'b0}; // [RULE_11]
              n.tx_left = c.txsc[TX_NINE] ? 4'd11 : 4'd10;
              n.tx_sub  = ovs(c.txsc[TX_HIGH]);
              n.tx_st   = TX_ASYNC;
            end else begin
              n.tx_sh   = {2'b11, c.txsc[TX_D9], c.txbuf}; // [RULE_11]
              n.tx_left = c.txsc[TX_NINE] ? 4'd9 : 4'd8;
              n.tx_st   = TX_SHIFT;
            end
          end
        end
        TX_ASYNC: begin
          if (tick) begin
            if (c.tx_sub == 7'h00) begin
              n.tx_sub  = ovs(c.txsc[TX_HIGH]);
              n.tx_sh   = {1'b1, c.tx_sh[10:1]};
              n.tx_left = c.tx_left - 4'd1;
              if (c.tx_left == 4'd1) begin
                n.tx_st = TX_IDLE;
              end
            end else begin
              n.tx_sub = c.tx_sub - 7'h01;
            end
          end
        end
        TX_SHIFT: begin
          // Master shifts on its own falling edge, slave on the pin's
          if (c.txsc[TX_CLOCK_SOURCE_SELECT]) begin // [RULE_08]
            if (tick) begin
              n.ck = ~c.ck;
              if (c.ck) begin
                n.tx_sh   = {1'b1, c.tx_sh[10:1]};
                n.tx_left = c.tx_left - 4'd1;
                if (c.tx_left == 4'd1) begin
                  n.tx_st = TX_IDLE;
                end
              end
            end
          end else if (c.ck_in_prev && !pin_in[i].clock_in) begin // [RULE_08]
            n.tx_sh   = {1'b1, c.tx_sh[10:1]};
            n.tx_left = c.tx_left - 4'd1;
            if (c.tx_left == 4'd1) begin
              n.tx_st = TX_IDLE;
            end
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
      if (!tx_ok) begin
        // Dropping the enable aborts a frame in flight
        n.tx_st = TX_IDLE; // [RULE_09]
        n.ck    = 1'b0;
        n.tx_sh = 11'h7ff;
      end

      //////////////////////////////////////////////////////////////////////
      // Bus read clears ready before the receiver may set it again
      if (mine && !pwrite && sel_reg == 3'h3) begin
        n.rx_full = 1'b0;
      end
      case (c.rx_st)
        RX_IDLE: begin
          if (rx_ok && !pin_in[i].data_in) begin
            n.rx_st  = RX_START;
            n.rx_sub = ovs(c.txsc[TX_HIGH]) >> 1;
          end
        end
        RX_START: begin
          if (tick) begin
            if (c.rx_sub == 7'h00) begin
              n.rx_sub  = ovs(c.txsc[TX_HIGH]);
              n.rx_left = c.rxsc[RX_NINE] ? 4'd10 : 4'd9;
              // A glitch shorter than half a bit is not a start
              n.rx_st   = pin_in[i].data_in ? RX_IDLE : RX_DATA;
            end else begin
              n.rx_sub = c.rx_sub - 7'h01;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (c.rx_sub == 7'h00) begin
              n.rx_sub  = ovs(c.txsc[TX_HIGH]);
              n.rx_left = c.rx_left - 4'd1;
              if (c.rx_left == 4'd1) begin
                n.rx_st = RX_IDLE;
                if (c.rx_full) begin
                  n.rxsc[RX_OERR] = 1'b1;
                end else begin
                  n.rx_full       = 1'b1;
                  n.rxsc[RX_FERR] = ~pin_in[i].data_in;
                  n.rxbuf         = c.rxsc[RX_NINE] ? c.rx_sh[7:0] : c.rx_sh[8:1];
                  n.rxsc[RX_D9]   = c.rxsc[RX_NINE] & c.rx_sh[8];
                end
              end else begin
                n.rx_sh = {pin_in[i].data_in, c.rx_sh[8:1]};
              end
            end else begin
              n.rx_sub = c.rx_sub - 7'h01;
            end
          end
        end
        default: n.rx_st = RX_IDLE;
      endcase
      if (!rx_ok) begin
        n.rx_st = RX_IDLE;
      end
      if (!c.rxsc[RX_CONTINUOUS_RECEIVE_ENABLE]) begin
        n.rxsc[RX_OERR] = 1'b0;
      end

      //////////////////////////////////////////////////////////////////////
      // Bus writes come last so a software load wins over a clear
      if (mine && pwrite) begin
        case (sel_reg)
          3'h0: n.txsc = (n.txsc & ~TXSC_WMASK) | (pwdata[7:0] & TXSC_WMASK); // [RULE_03]
          3'h1: n.rxsc = (n.rxsc & ~RXSC_WMASK) | (pwdata[7:0] & RXSC_WMASK); // [RULE_03]
          3'h2: begin
            n.txbuf   = pwdata[7:0];
            n.tx_full = 1'b1;
          end
          3'h4: n.baud = pwdata[7:0];
          default: n.baud = n.baud;
        endcase
      end
      n.txsc[TX_EMPTY] = (n.tx_st == TX_IDLE);
      n.txsc[3]        = 1'b0;
      next_st.ch[i]    = n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{ch: '{default: CH_RESET}, rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // Pins are only taken while the port is enabled
      pin_out[i].clock_oe  = st.ch[i].rxsc[RX_SERIAL_PORT_ENABLE] &
                             (~st.ch[i].txsc[TX_SYNC] | st.ch[i].txsc[TX_CLOCK_SOURCE_SELECT]); // [RULE_10] [RULE_01]
      pin_out[i].clock_out = st.ch[i].txsc[TX_SYNC] ? st.ch[i].ck :
                             (st.ch[i].tx_st == TX_ASYNC ? st.ch[i].tx_sh[0] : 1'b1);
      pin_out[i].data_oe   = st.ch[i].rxsc[RX_SERIAL_PORT_ENABLE] & st.ch[i].txsc[TX_SYNC] &
                             (st.ch[i].tx_st == TX_SHIFT); // [RULE_01]
      pin_out[i].data_out  = st.ch[i].tx_sh[0];
    end
  end

endmodule

// >>> testbench/serial_port_partner.sv
`timescale 1ns/1ps
module serial_port_partner
  import serial_port_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               loop_on,
  input  wire logic               slave_run,
  input  wire pin_out_s [NCH-1:0] pin_out,
  output pin_in_s       [NCH-1:0] pin_in
);
  logic [1:0] div;
  logic       ext_ck;
  logic       ck;
  // Peer clock runs only inside slave frames, idle low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div    <= 2'h0;
      ext_ck <= 1'b0;
    end else if (!slave_run) begin
      div    <= 2'h0;
      ext_ck <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        ext_ck <= ~ext_ck;
      end
    end
  end
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ck = pin_out[c].clock_oe ? pin_out[c].clock_out : ext_ck;
      pin_in[c].clock_in = ck;
      // Released pin sits at pull-up; loop echoes line
      pin_in[c].data_in = pin_out[c].data_oe ? pin_out[c].data_out : (loop_on ? ck : 1'b1);
    end
  end
endmodule

// >>> testbench/serial_port_pair_sva.sv
`timescale 1ns/1ps
module serial_port_pair_sva
  import serial_port_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire pin_in_s  [NCH-1:0] pin_in,
  input wire pin_out_s [NCH-1:0] pin_out
);
  logic [7:0] tx [NCH];
  logic [7:0] rx [NCH];
  logic       bad;
  assign bad = paddr[7:6] != 2'h0 || !(paddr[4:0] inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10});
  // Shadow copies of the writable control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx <= '{default: 8'h00};
      rx <= '{default: 8'h00};
    end else if (psel && penable && pwrite && !bad) begin
      if (paddr[4:0] == 5'h00) tx[paddr[5]] <= pwdata[7:0];
      if (paddr[4:0] == 5'h04) rx[paddr[5]] <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence async_on_s;
    rx[0][7] && !tx[0][4];
  endsequence
  sequence tx_off_s;
    rx[0][7] && !tx[0][5] && !tx[0][4];
  endsequence
  slverr_map_a: assert property (psel && penable |-> pslverr == bad)
    else $error("slave error does not match map");
  err_data_a: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  clk_dir0_a: assert property (pin_out[0].clock_oe == (rx[0][7] && (!tx[0][4] || tx[0][7])))
    else $error("clock pin direction wrong on port 0");
  clk_dir1_a: assert property (pin_out[1].clock_oe == (rx[1][7] && (!tx[1][4] || tx[1][7])))
    else $error("clock pin direction wrong on port 1");
  off_quiet_a: assert property (!rx[0][7] [*2] |-> !pin_out[0].data_oe && !pin_out[0].clock_oe)
    else $error("disabled port drives a pin");
  async_quiet_a: assert property (async_on_s [*2] |-> !pin_out[0].data_oe)
    else $error("data pin driven in asynchronous mode");
  idle_high_a: assert property (tx_off_s [*2] |-> pin_out[0].clock_out)
    else $error("line not idle with transmitter off");
  start_len_a: assert property ($fell(pin_out[0].clock_out) && rx[0][7] && !tx[0][4]
    && tx[0][5] |-> (!pin_out[0].clock_out || !tx[0][5]) [*8])
    else $error("asynchronous low bit too short");
  ms_stable_a: assert property ($rose(pin_out[1].clock_out) && $past(pin_out[1].data_oe)
    && pin_out[1].data_oe |-> $stable(pin_out[1].data_out))
    else $error("master data moved at clock rise");
endmodule
bind serial_port_pair serial_port_pair_sva sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out));

// >>> testbench/serial_port_pair_tb.sv
`timescale 1ns/1ps
module serial_port_pair_tb;
  import serial_port_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic               loop_on, slave_run;
  logic [7:0]         paddr, b, v;
  logic [31:0]        pwdata, prdata, rd;
  pin_in_s  [NCH-1:0] pin_in;
  pin_out_s [NCH-1:0] pin_out;
  int                 num_errors, total_checks, cyc;
  serial_port_pair DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out));
  serial_port_partner peer (.pclk(pclk), .presetn(presetn), .loop_on(loop_on),
    .slave_run(slave_run), .pin_out(pin_out), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic async_frame(input int c, input logic [8:0] d, input int n);
    for (int i = 0; i < 300 && pin_out[c].clock_out !== 1'b0; i++) @(posedge pclk);
    repeat (8) @(posedge pclk);
    chk(32'(pin_out[c].clock_out), 32'h0);
    for (int i = 0; i <= n; i++) begin
      repeat (16) @(posedge pclk);
      chk(32'(pin_out[c].clock_out), i < n ? 32'(d[i]) : 32'h1);
    end
  endtask
  task automatic edge_bits(input int c, input logic ext, input logic [7:0] d);
    logic lo;
    for (int i = 0; i < 8; i++) begin
      lo = 1'b0;
      for (int k = 0; k < 64; k++) begin
        @(posedge pclk);
        if ((ext ? pin_in[c].clock_in : pin_out[c].clock_out) === 1'b0) lo = 1'b1;
        else if (lo) break;
      end
      chk(32'({pin_out[c].data_oe, pin_out[c].data_out}), {30'h0, 1'b1, d[i]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 20000) begin
        num_errors++;
        conclude();
      end
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, loop_on, slave_run} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(94144));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int c = 0; c < 2; c++) begin
      rchk(8'(c * 32), 32'h02);
      rchk(8'(c * 32 + 4), 32'h00);
    end
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      for (int c = 0; c < 2; c++)
        for (int o = 0; o < 20; o += 4) if (o != 8 && o != 12) apb(1'b1, 8'(c * 32 + o), c ? ~b : b);
      for (int c = 0; c < 2; c++) begin
        v = c ? ~b : b;
        rchk(8'(c * 32), {24'h0, (v & 8'hf5) | 8'h02});
        rchk(8'(c * 32 + 4), {24'h0, v & 8'hf8});
        rchk(8'(c * 32 + 16), {24'h0, v});
      end
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h40, 32'hff);
    chk(32'(err), 32'h1);
    loop_on <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      b = 8'($urandom);
      // Port off first so the baud counter reloads at once
      apb(1'b1, 8'(c * 32 + 4), 32'h0);
      apb(1'b1, 8'(c * 32 + 16), 32'h0);
      apb(1'b1, 8'(c * 32 + 4), 32'h90);
      apb(1'b1, 8'(c * 32), c ? 32'h64 : 32'h24);
      apb(1'b1, 8'(c * 32 + 8), {24'h0, b});
      async_frame(c, {1'b0, b}, c ? 9 : 8);
      repeat (16) @(posedge pclk);
      rchk(8'(c * 32 + 12), {23'h0, 1'b1, b});
    end
    apb(1'b1, 8'h08, 32'h0);
    repeat (40) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h04);
    // Abort lands one edge after the write
    @(posedge pclk);
    chk(32'(pin_out[0].clock_out), 32'h1);
    rchk(8'h00, 32'h06);
    b = 8'($urandom);
    apb(1'b1, 8'h30, 32'h1);
    apb(1'b1, 8'h24, 32'h80);
    apb(1'b1, 8'h20, 32'hb4);
    fork
      apb(1'b1, 8'h28, {24'h0, b});
      edge_bits(1, 1'b0, b);
    join
    b = 8'($urandom);
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h00, 32'h34);
    chk(32'(pin_out[0].clock_oe), 32'h0);
    apb(1'b1, 8'h08, {24'h0, b});
    slave_run <= 1'b1;
    edge_bits(0, 1'b1, b);
    repeat (16) @(posedge pclk);
    slave_run <= 1'b0;
    apb(1'b1, 8'h00, 32'h24);
    chk(32'(pin_out[0].clock_oe), 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    chk({pin_out[0].clock_oe, pin_out[0].data_oe}, 32'h0);
    conclude();
  end
endmodule
